// *** hdl/port_pins_reset_clock.sv ***
`timescale 1ns/10ps
`include "port_pins_params.svh"
module port_pins_reset_clock
  import port_pins_pkg::*;
(
  input wire logic clk_i,                  // oscillator clock, 20 MHz
  input wire logic reset_i,                // reset pin, active high
  input wire logic [7:0] first_port_in_i,  // first port pin levels
  output logic [7:0] first_port_out_o,     // first port drive value
  output logic [7:0] first_port_oe_o,      // first port drive enable
  output logic [7:0] first_pullup_o,       // first port pull-up present
  input wire logic [7:0] second_port_in_i, // second port pin levels
  output logic [7:0] second_port_out_o,    // second port drive value
  output logic [7:0] second_port_oe_o,     // second port drive enable
  output logic [7:0] second_pullup_o,      // second port pull-up present
  input wire logic comparator_out_i,       // comparator result
  output logic comparator_pos_in_o,        // comparator positive input level
  output logic comparator_neg_in_o,        // comparator negative input level
  input wire logic first_wr_i,             // first port latch write
  input wire logic [7:0] first_wdata_i,    // first port latch data
  input wire logic second_wr_i,            // second port latch write
  input wire logic [7:0] second_wdata_i,   // second port latch data
  output logic [7:0] first_pins_o,         // first port read value
  output logic [7:0] second_pins_o,        // second port read value
  input wire logic serial_tx_i,            // serial transmit from core
  output logic serial_rx_o,                // serial receive to core
  output logic ext_irq_zero_o,             // external interrupt 0 level
  output logic ext_irq_one_o,              // external interrupt 1 level
  output logic timer_zero_in_o,            // timer 0 count input
  output logic timer_one_in_o,             // timer 1 count input
  input wire logic pd_request_i,           // enter power-down, pulse
  output logic pd_active_o,                // power-down in force
  input wire logic prog_mode_i,            // flash programming mode
  input wire logic prog_verify_i,          // verify: drive code out
  input wire logic [7:0] prog_code_i,      // code byte to present
  output logic [7:0] prog_code_o,          // code byte received
  output logic [7:0] prog_ctrl_o,          // programming control levels
  output logic machine_cycle_o,            // machine cycle pulse
  output logic clk_phase_o,                // half-rate clock pulse
  output logic device_reset_o              // whole-device reset
);

  port_state_t st_reg;
  port_state_t st_next;
  logic full_reset;
  logic [7:0] second_eff;

  clk_ctrl_if clk_ctl ();

  // twelve-period machine cycle generator
  machine_clock u_clock (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ctl(clk_ctl.gen)
  );

  // reset pin width qualifier
  reset_filter u_reset (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .osc_run_i(st_reg.osc_run),
    .full_reset_o(full_reset)
  );

  assign clk_ctl.osc_run = st_reg.osc_run;

  // latch value after alternate output gating
  function automatic logic [7:0] gate_tx(input logic [7:0] latch, input logic tx);
    logic [7:0] r;
    r = latch;
    r[`TX_BIT] = latch[`TX_BIT] & tx;
    return r;
  endfunction

  // mode control, latches, sampling and pin drive
  always_comb
  begin
    st_next = st_reg;
    st_next.first_pullup = `FIRST_PULLUP_MASK;
    st_next.second_pullup = `SECOND_PULLUP_MASK;
    st_next.mc_tick = 1'b0;
    st_next.half_tick = 1'b0;
    st_next.dev_reset = full_reset;
    second_eff = 8'h00;
    if (st_reg.mode != mode_pd)
    begin
      // pin reads return real levels, comparator on position 6
      st_next.first_pins = first_port_in_i;
      st_next.second_pins = second_port_in_i;
      st_next.second_pins[`CMP_OUT_BIT] = comparator_out_i;
      st_next.cmp_pos = first_port_in_i[`CMP_POS_BIT];
      st_next.cmp_neg = first_port_in_i[`CMP_NEG_BIT];
      st_next.rx = second_port_in_i[`RX_BIT];
      st_next.irq0 = second_port_in_i[`IRQ0_BIT];
      st_next.irq1 = second_port_in_i[`IRQ1_BIT];
      st_next.tmr0 = second_port_in_i[`TMR0_BIT];
      st_next.tmr1 = second_port_in_i[`TMR1_BIT];
      st_next.mc_tick = clk_ctl.mc_tick;
      st_next.half_tick = clk_ctl.half_tick;
    end
    unique case (st_reg.mode)
      mode_run:
      begin
        if (first_wr_i)
          st_next.first_latch = first_wdata_i;
        if (second_wr_i)
          st_next.second_latch = second_wdata_i;
        if (prog_mode_i)
          st_next.mode = mode_prog;
        else if (pd_request_i)
        begin
          st_next.mode = mode_pd;
          st_next.osc_run = 1'b0;
        end
      end
      mode_pd:
      begin
        st_next.mode = mode_pd;
      end
      mode_prog:
      begin
        st_next.prog_code = first_port_in_i;
        st_next.prog_ctrl = second_port_in_i;
        if (!prog_mode_i)
          st_next.mode = mode_run;
      end
    endcase
    // reset pin: ports to ones, oscillator back on
    if (reset_i)
    begin
      st_next.first_latch = `PORT_RESET;
      st_next.second_latch = `PORT_RESET;
      st_next.mode = mode_run;
      st_next.osc_run = 1'b1;
    end
    // pin drivers: programming releases all but the verify code byte; else strong low for a zero latch or low tx on second port 1, except second port 6
    if (st_next.mode == mode_prog)
    begin
      st_next.first_out = prog_verify_i ? prog_code_i : 8'h00;
      st_next.first_oe = prog_verify_i ? 8'hff : 8'h00;
      st_next.second_out = 8'h00;
      st_next.second_oe = 8'h00;
    end
    else
    begin
      second_eff = gate_tx(st_next.second_latch, serial_tx_i | reset_i);
      st_next.first_out = 8'h00;
      st_next.first_oe = ~st_next.first_latch;
      st_next.second_out = 8'h00;
      st_next.second_oe = ~second_eff & `SECOND_GPIO_MASK;
    end
    st_next.pd_active = (st_next.mode == mode_pd);
  end

  always_ff @(posedge clk_i)
  begin
    st_reg <= st_next;
  end

  // outputs straight from the state register
  assign first_port_out_o = st_reg.first_out;
  assign first_port_oe_o = st_reg.first_oe;
  assign first_pullup_o = st_reg.first_pullup;
  assign second_port_out_o = st_reg.second_out;
  assign second_port_oe_o = st_reg.second_oe;
  assign second_pullup_o = st_reg.second_pullup;
  assign comparator_pos_in_o = st_reg.cmp_pos;
  assign comparator_neg_in_o = st_reg.cmp_neg;
  assign first_pins_o = st_reg.first_pins;
  assign second_pins_o = st_reg.second_pins;
  assign serial_rx_o = st_reg.rx;
  assign ext_irq_zero_o = st_reg.irq0;
  assign ext_irq_one_o = st_reg.irq1;
  assign timer_zero_in_o = st_reg.tmr0;
  assign timer_one_in_o = st_reg.tmr1;
  assign pd_active_o = st_reg.pd_active;
  assign prog_code_o = st_reg.prog_code;
  assign prog_ctrl_o = st_reg.prog_ctrl;
  assign machine_cycle_o = st_reg.mc_tick;
  assign clk_phase_o = st_reg.half_tick;
  assign device_reset_o = st_reg.dev_reset;

  pullup_map_a: assert property (@(posedge clk_i) disable iff (reset_i)
    first_pullup_o == 8'hfc && !first_port_out_o[0] && !first_port_out_o[1]
    || st_reg.mode == mode_prog)
    else $error("first port pull-up map wrong");

  second_map_a: assert property (@(posedge clk_i) disable iff (reset_i)
    second_pullup_o == 8'hbf)
    else $error("second port pull-up map wrong");

  cmp_inputs_a: assert property (@(posedge clk_i) disable iff (reset_i)
    st_reg.mode != mode_pd |=> comparator_pos_in_o == $past(first_port_in_i[0])
    && comparator_neg_in_o == $past(first_port_in_i[1]))
    else $error("comparator inputs not taken from first port");

  latch_input_a: assert property (@(posedge clk_i) disable iff (reset_i)
    st_reg.mode == mode_run && first_wr_i && !prog_mode_i && !pd_request_i
    |=> first_port_oe_o == ~$past(first_wdata_i) ##1 first_pins_o == $past(first_port_in_i))
    else $error("latch write not steering first port drive");

  cmp_pin_a: assert property (@(posedge clk_i) disable iff (reset_i)
    st_reg.mode != mode_pd |=> !second_port_oe_o[6] && second_pins_o[6] == $past(comparator_out_i))
    else $error("second port position 6 not comparator only");

  alt_func_a: assert property (@(posedge clk_i) disable iff (reset_i)
    st_reg.mode != mode_pd |=> serial_rx_o == $past(second_port_in_i[0])
    && ext_irq_zero_o == $past(second_port_in_i[2]) && ext_irq_one_o == $past(second_port_in_i[3])
    && timer_zero_in_o == $past(second_port_in_i[4]) && timer_one_in_o == $past(second_port_in_i[5]))
    else $error("alternate inputs not routed");

  tx_gate_a: assert property (@(posedge clk_i) disable iff (reset_i)
    st_next.mode == mode_run && st_next.second_latch[1] |=> second_port_oe_o[1] == !$past(serial_tx_i))
    else $error("serial transmit not gating position 1");

  reset_ones_a: assert property (@(posedge clk_i)
    reset_i |=> first_port_oe_o == 8'h00 && second_port_oe_o == 8'h00 && !pd_active_o)
    else $error("pins not released to ones under reset");

  prog_port_a: assert property (@(posedge clk_i) disable iff (reset_i)
    st_reg.mode == mode_prog && prog_mode_i && prog_verify_i
    |=> first_port_oe_o == 8'hff && first_port_out_o == $past(prog_code_i) && second_port_oe_o == 8'h00)
    else $error("programming port roles wrong");

  pd_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    pd_active_o |=> pd_active_o && !st_reg.osc_run && $stable(first_pins_o) && !machine_cycle_o)
    else $error("power-down left or clock running without reset");

  pin_drive_a: assert property (@(posedge clk_i) disable iff (reset_i)
    st_reg.mode == mode_run |-> first_port_out_o == 8'h00 && first_port_oe_o == ~st_reg.first_latch)
    else $error("first port drive not from latch");

  // second latch write, with transmit gating on position 1
  second_latch_a: assert property (@(posedge clk_i) disable iff (reset_i)
    st_reg.mode == mode_run && second_wr_i && !prog_mode_i && !pd_request_i
    |=> second_port_oe_o == (~($past(second_wdata_i) & {6'h3f, $past(serial_tx_i), 1'b1}) & 8'hbf))
    else $error("latch write not steering second port drive");

  second_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
    second_port_out_o == 8'h00 && (st_reg.mode == mode_prog || first_port_out_o == 8'h00))
    else $error("port drives a high level outside verify");

  // power-down entry, refused writes and frozen sampling
  pd_entry_a: assert property (@(posedge clk_i) disable iff (reset_i)
    st_reg.mode == mode_run && pd_request_i && !prog_mode_i |=> pd_active_o && !st_reg.osc_run)
    else $error("power-down request not taken");

  pd_refuse_a: assert property (@(posedge clk_i) disable iff (reset_i)
    pd_active_o |=> $stable(first_port_oe_o))
    else $error("first port drive changed in power-down");

  pd_freeze_a: assert property (@(posedge clk_i) disable iff (reset_i)
    pd_active_o |=> $stable(second_pins_o) && $stable(serial_rx_o) && !clk_phase_o)
    else $error("port sampling running in power-down");

  // programming entry, capture and exit
  prog_entry_a: assert property (@(posedge clk_i) disable iff (reset_i)
    st_reg.mode == mode_run && prog_mode_i |=> st_reg.mode == mode_prog && second_port_oe_o == 8'h00)
    else $error("programming mode not entered");

  prog_capture_a: assert property (@(posedge clk_i) disable iff (reset_i)
    st_reg.mode == mode_prog
    |=> prog_code_o == $past(first_port_in_i) && prog_ctrl_o == $past(second_port_in_i))
    else $error("programming ports not captured");

  prog_exit_a: assert property (@(posedge clk_i) disable iff (reset_i)
    st_reg.mode == mode_prog && !prog_mode_i |=> st_reg.mode == mode_run)
    else $error("programming mode not left");

  // reset state and release of the qualified device reset
  reset_state_a: assert property (@(posedge clk_i)
    reset_i |=> st_reg.first_latch == 8'hff && st_reg.second_latch == 8'hff && st_reg.mode == mode_run)
    else $error("latches not set to ones by reset");

  dev_release_a: assert property (@(posedge clk_i)
    !reset_i |-> ##2 !device_reset_o)
    else $error("device reset held after reset pin fell");

  // tick spacing as seen at the outputs
  mc_space_a: assert property (@(posedge clk_i) disable iff (reset_i)
    machine_cycle_o |=> !machine_cycle_o [*8])
    else $error("machine cycle pulses too close");

  mc_phase_a: assert property (@(posedge clk_i) disable iff (reset_i)
    machine_cycle_o |-> clk_phase_o)
    else $error("machine cycle off the half-rate phase");

  phase_space_a: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_phase_o |=> !clk_phase_o)
    else $error("half-rate pulses back to back");

endmodule

// *** hdl/port_pins_params.svh ***
`ifndef PORT_PINS_PARAMS_SVH
`define PORT_PINS_PARAMS_SVH

// clocking: oscillator periods per machine cycle, halved by the input toggle stage
`define OSC_PER_MC 12
`define DIV_RATIO 2
`define HALF_PER_MC (`OSC_PER_MC / `DIV_RATIO)

// reset pin must stand high this many machine cycles
`define RESET_MC_MIN 2
`define RESET_OSC_MIN (`RESET_MC_MIN * `OSC_PER_MC)

// port reset values and pin maps
`define PORT_RESET 8'hff
`define FIRST_PULLUP_MASK 8'hfc
`define SECOND_PULLUP_MASK 8'hbf
`define SECOND_GPIO_MASK 8'hbf

// bit positions of shared functions
`define CMP_POS_BIT 0
`define CMP_NEG_BIT 1
`define RX_BIT 0
`define TX_BIT 1
`define IRQ0_BIT 2
`define IRQ1_BIT 3
`define TMR0_BIT 4
`define TMR1_BIT 5
`define CMP_OUT_BIT 6
`define TOP_BIT 7

`endif

// *** hdl/port_pins_pkg.sv ***
package port_pins_pkg;

  // operating modes, one-hot
  typedef enum logic [2:0] {
    mode_run = 3'b001,
    mode_pd = 3'b010,
    mode_prog = 3'b100
  } mode_t;

  // divider state
  typedef struct packed {
    logic div2;
    logic [2:0] half_cnt;
    logic half_tick;
    logic mc_tick;
    logic [3:0] gap_cnt;
    logic gap_valid;
  } clk_state_t;

  // reset pin qualifier state
  typedef struct packed {
    logic [4:0] cnt;
    logic full;
  } rst_state_t;

  // port block state
  typedef struct packed {
    mode_t mode;
    logic [7:0] first_latch;
    logic [7:0] second_latch;
    logic [7:0] first_out;
    logic [7:0] first_oe;
    logic [7:0] second_out;
    logic [7:0] second_oe;
    logic [7:0] first_pins;
    logic [7:0] second_pins;
    logic [7:0] first_pullup;
    logic [7:0] second_pullup;
    logic [7:0] prog_code;
    logic [7:0] prog_ctrl;
    logic cmp_pos;
    logic cmp_neg;
    logic rx;
    logic irq0;
    logic irq1;
    logic tmr0;
    logic tmr1;
    logic pd_active;
    logic osc_run;
    logic mc_tick;
    logic half_tick;
    logic dev_reset;
  } port_state_t;

endpackage

// *** hdl/clk_ctrl_if.sv ***
`timescale 1ns/10ps
// ticks from the divider and the run gate back to it
interface clk_ctrl_if;
  logic osc_run;
  logic half_tick;
  logic mc_tick;

  modport gen (input osc_run, output half_tick, output mc_tick);
  modport use_side (output osc_run, input half_tick, input mc_tick);
endinterface

// *** hdl/machine_clock.sv ***
`timescale 1ns/10ps
`include "port_pins_params.svh"
module machine_clock
  import port_pins_pkg::*;
(
  input wire logic clk_i,   // oscillator clock
  input wire logic reset_i, // synchronous reset
  clk_ctrl_if.gen ctl       // ticks out, run gate in
);

  clk_state_t st_reg;
  clk_state_t st_next;

  // divide by two, then count half ticks to a machine cycle
  always_comb
  begin
    st_next = st_reg;
    st_next.half_tick = 1'b0;
    st_next.mc_tick = 1'b0;
    if (reset_i)
    begin
      st_next = '0;
    end
    else if (ctl.osc_run)
    begin
      st_next.div2 = ~st_reg.div2;
      if (st_reg.div2)
      begin
        st_next.half_tick = 1'b1;
        if (st_reg.half_cnt == 3'(`HALF_PER_MC - 1))
        begin
          st_next.half_cnt = 3'h0;
          st_next.mc_tick = 1'b1;
        end
        else
          st_next.half_cnt = st_reg.half_cnt + 3'h1;
      end
      st_next.gap_cnt = st_reg.mc_tick ? 4'h0 : st_reg.gap_cnt + 4'h1;
      st_next.gap_valid = st_reg.gap_valid | st_reg.mc_tick;
    end
    else
    begin
      st_next.gap_valid = 1'b0; // stopped oscillator breaks the spacing check
    end
  end

  always_ff @(posedge clk_i)
  begin
    st_reg <= st_next;
  end

  assign ctl.half_tick = st_reg.half_tick;
  assign ctl.mc_tick = st_reg.mc_tick;

  mc_period_a: assert property (@(posedge clk_i) disable iff (reset_i)
    st_reg.mc_tick && st_reg.gap_valid |-> st_reg.gap_cnt == 4'hb)
    else $error("machine cycle not twelve oscillator periods");

  half_rate_a: assert property (@(posedge clk_i) disable iff (reset_i)
    st_reg.half_tick && ctl.osc_run |=> !st_reg.half_tick ##1
    (st_reg.half_tick || $past(!ctl.osc_run) || $past(reset_i)))
    else $error("half tick not every second oscillator period");

endmodule

// *** hdl/reset_filter.sv ***
`timescale 1ns/10ps
`include "port_pins_params.svh"
module reset_filter
  import port_pins_pkg::*;
(
  input wire logic clk_i,       // oscillator clock
  input wire logic reset_i,     // reset pin level
  input wire logic osc_run_i,   // oscillator running
  output logic full_reset_o     // whole-device reset, held
);

  rst_state_t st_reg;
  rst_state_t st_next;

  // count running oscillator periods while the pin stands high
  always_comb
  begin
    st_next = st_reg;
    if (!reset_i)
    begin
      st_next = '0;
    end
    else if (osc_run_i && st_reg.cnt != 5'(`RESET_OSC_MIN))
    begin
      st_next.cnt = st_reg.cnt + 5'h1;
      st_next.full = (st_reg.cnt == 5'(`RESET_OSC_MIN - 1));
    end
  end

  always_ff @(posedge clk_i)
  begin
    st_reg <= st_next;
  end

  assign full_reset_o = st_reg.full;

  reset_width_a: assert property (@(posedge clk_i)
    $rose(st_reg.full) |-> $past(reset_i, 24) && $past(reset_i, 12) && $past(reset_i, 1))
    else $error("device reset before two machine cycles of reset pin");

  reset_drop_a: assert property (@(posedge clk_i)
    !reset_i |=> !st_reg.full)
    else $error("device reset held after reset pin fell");

endmodule

// *** test/board_pins_model.sv ***
`timescale 1ns/10ps
module board_pins_model #(
  parameter logic [7:0] FIRST_EXT_PULLUP = 8'h03,  // board pull-ups on comparator pins
  parameter logic [7:0] SECOND_EXT_PULLUP = 8'h00  // no board pull-ups on second port
)
(
  input wire logic clk_i,                // oscillator clock
  input wire logic [7:0] first_out_i,    // device drive value
  input wire logic [7:0] first_oe_i,     // device drive enable
  input wire logic [7:0] first_pullup_i, // device pull-ups
  input wire logic [7:0] second_out_i,   // device drive value
  input wire logic [7:0] second_oe_i,    // device drive enable
  input wire logic [7:0] second_pullup_i, // device pull-ups
  input wire logic [7:0] first_en_i,     // board drives first port
  input wire logic [7:0] first_val_i,    // board level first port
  input wire logic [7:0] second_en_i,    // board drives second port
  input wire logic [7:0] second_val_i,   // board level second port
  output logic [7:0] first_pins_o,       // resolved first port
  output logic [7:0] second_pins_o       // resolved second port
);
  logic flip_reg = 1'b0;

  // floating pins wander every cycle
  always @(posedge clk_i)
    flip_reg <= ~flip_reg;

  // strong device low wins, then device high, board, pull-ups, float
  function automatic logic [7:0] resolve(input logic [7:0] o, input logic [7:0] oe, input logic [7:0] pu,
                                         input logic [7:0] en, input logic [7:0] v, input logic [7:0] xpu,
                                         input logic fl);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = oe[i] ? o[i] : en[i] ? v[i] : (pu[i] | xpu[i]) ? 1'b1 : fl ^ i[0];
    return r;
  endfunction

  // wander state passed in so the pins follow it
  assign first_pins_o = resolve(first_out_i, first_oe_i, first_pullup_i, first_en_i, first_val_i,
                                FIRST_EXT_PULLUP, flip_reg);
  assign second_pins_o = resolve(second_out_i, second_oe_i, second_pullup_i, second_en_i, second_val_i,
                                 SECOND_EXT_PULLUP, flip_reg);
endmodule

// *** test/port_pins_reset_clock_test.sv ***
`timescale 1ns/10ps
`define chk(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module port_pins_reset_clock_test;
  logic clk_i, reset_i, comparator_out_i, first_wr_i, second_wr_i, serial_tx_i;
  logic pd_request_i, prog_mode_i, prog_verify_i;
  logic [7:0] first_wdata_i, second_wdata_i, prog_code_i, f_en, f_val, s_en, s_val;
  logic [7:0] first_port_in_i, first_port_out_o, first_port_oe_o, first_pullup_o;
  logic [7:0] second_port_in_i, second_port_out_o, second_port_oe_o, second_pullup_o;
  logic [7:0] first_pins_o, second_pins_o, prog_code_o, prog_ctrl_o, l1, l2, eff, ex1, ex2;
  logic comparator_pos_in_o, comparator_neg_in_o, serial_rx_o, ext_irq_zero_o, ext_irq_one_o;
  logic timer_zero_in_o, timer_one_in_o, pd_active_o, machine_cycle_o, clk_phase_o, device_reset_o;
  int mismatches = 0;
  int checks = 0;
  int seed = 32'hcb0bff94;
  int n;

  port_pins_reset_clock u_dut (.clk_i(clk_i), .reset_i(reset_i), .first_port_in_i(first_port_in_i),
    .first_port_out_o(first_port_out_o), .first_port_oe_o(first_port_oe_o), .first_pullup_o(first_pullup_o),
    .second_port_in_i(second_port_in_i), .second_port_out_o(second_port_out_o),
    .second_port_oe_o(second_port_oe_o), .second_pullup_o(second_pullup_o), .comparator_out_i(comparator_out_i),
    .comparator_pos_in_o(comparator_pos_in_o), .comparator_neg_in_o(comparator_neg_in_o),
    .first_wr_i(first_wr_i), .first_wdata_i(first_wdata_i), .second_wr_i(second_wr_i),
    .second_wdata_i(second_wdata_i), .first_pins_o(first_pins_o), .second_pins_o(second_pins_o),
    .serial_tx_i(serial_tx_i), .serial_rx_o(serial_rx_o), .ext_irq_zero_o(ext_irq_zero_o),
    .ext_irq_one_o(ext_irq_one_o), .timer_zero_in_o(timer_zero_in_o), .timer_one_in_o(timer_one_in_o),
    .pd_request_i(pd_request_i), .pd_active_o(pd_active_o), .prog_mode_i(prog_mode_i),
    .prog_verify_i(prog_verify_i), .prog_code_i(prog_code_i), .prog_code_o(prog_code_o),
    .prog_ctrl_o(prog_ctrl_o), .machine_cycle_o(machine_cycle_o), .clk_phase_o(clk_phase_o),
    .device_reset_o(device_reset_o));

  board_pins_model u_board (.clk_i(clk_i), .first_out_i(first_port_out_o), .first_oe_i(first_port_oe_o),
    .first_pullup_i(first_pullup_o), .second_out_i(second_port_out_o), .second_oe_i(second_port_oe_o),
    .second_pullup_i(second_pullup_o), .first_en_i(f_en), .first_val_i(f_val), .second_en_i(s_en),
    .second_val_i(s_val), .first_pins_o(first_port_in_i), .second_pins_o(second_port_in_i));

  // 20 MHz oscillator
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // expected read value: latch zero pulls low, else board level or pull-up high
  function automatic logic [7:0] exp_pins(input logic [7:0] lat, input logic [7:0] en, input logic [7:0] v);
    return lat & (~en | v);
  endfunction

  // cycles between two pulses of a tick output
  task automatic gap(input bit mc, output int g);
    g = 0;
    while ((mc ? machine_cycle_o : clk_phase_o) !== 1'b1 && g < 40)
    begin
      cyc(1);
      g++;
    end
    g = 0;
    do
    begin
      cyc(1);
      g++;
    end
    while ((mc ? machine_cycle_o : clk_phase_o) !== 1'b1 && g < 40);
  endtask

  // watchdog
  initial
  begin
    #(50 * 3000);
    mismatches++;
    end_of_test;
  end

  initial
  begin
    {first_wr_i, second_wr_i, pd_request_i, prog_mode_i, prog_verify_i, comparator_out_i} = '0;
    {first_wdata_i, second_wdata_i, prog_code_i, f_en, f_val, s_en, s_val} = '0;
    serial_tx_i = 1'b1;
    reset_i = 1'b1;
    cyc(12);
    reset_i = 1'b0;
    cyc(3);
    `chk({first_port_oe_o, second_port_oe_o}, 16'h0000)
    `chk({first_pullup_o, second_pullup_o}, 16'hfcbf)
    `chk({first_pins_o, second_pins_o}, 16'hffbf)
    `chk(device_reset_o, 1'b0)
    // too short a hold gives no device reset, a long one does
    reset_i = 1'b1;
    cyc(23);
    `chk(device_reset_o, 1'b0)
    cyc(7);
    `chk(device_reset_o, 1'b1)
    reset_i = 1'b0;
    cyc(3);
    `chk(device_reset_o, 1'b0)
    l1 = 8'hff;
    l2 = 8'hff;
    // random latch writes against random board levels
    for (int i = 0; i < 40; i++)
    begin
      l1 = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : $random(seed);
      l2 = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : $random(seed);
      f_en = (i == 1) ? 8'hff : $random(seed);
      f_val = (i == 1) ? 8'h00 : $random(seed);
      s_en = (i == 0) ? 8'hbf : $random(seed);
      s_val = (i == 0) ? 8'h00 : $random(seed);
      serial_tx_i = $random(seed);
      comparator_out_i = $random(seed);
      first_wdata_i = l1;
      second_wdata_i = l2;
      first_wr_i = 1'b1;
      second_wr_i = 1'b1;
      cyc(1);
      first_wr_i = 1'b0;
      second_wr_i = 1'b0;
      cyc(3);
      eff = l2 & {6'h3f, serial_tx_i, 1'b1};
      ex1 = exp_pins(l1, f_en, f_val);
      ex2 = exp_pins(eff, s_en, s_val);
      `chk(first_port_oe_o, ~l1)
      `chk(second_port_oe_o, ~eff & 8'hbf)
      `chk({first_port_out_o, second_port_out_o}, 16'h0000)
      `chk(first_pins_o, ex1)
      `chk(second_pins_o, {ex2[7], comparator_out_i, ex2[5:0]})
      `chk({comparator_neg_in_o, comparator_pos_in_o}, ex1[1:0])
      `chk({timer_one_in_o, timer_zero_in_o, ext_irq_one_o, ext_irq_zero_o, serial_rx_o}, {ex2[5:2], ex2[0]})
    end
    gap(1'b1, n);
    `chk(n, 12)
    gap(1'b0, n);
    `chk(n, 2)
    // power-down: writes refused, machine cycles stop, reset exits
    pd_request_i = 1'b1;
    cyc(1);
    pd_request_i = 1'b0;
    `chk(pd_active_o, 1'b1)
    first_wdata_i = ~l1;
    first_wr_i = 1'b1;
    cyc(3);
    first_wr_i = 1'b0;
    n = 0;
    repeat (30)
    begin
      cyc(1);
      n += (machine_cycle_o !== 1'b0);
    end
    `chk(n, 0)
    `chk(first_port_oe_o, ~l1)
    reset_i = 1'b1;
    cyc(1);
    `chk({pd_active_o, first_port_oe_o}, 9'h000)
    cyc(29);
    reset_i = 1'b0;
    cyc(3);
    // programming: ports receive, then verify drives the code byte
    f_en = 8'hff;
    s_en = 8'hff;
    f_val = $random(seed);
    s_val = $random(seed);
    prog_mode_i = 1'b1;
    cyc(1);
    first_wdata_i = 8'h00;
    first_wr_i = 1'b1;
    cyc(1);
    first_wr_i = 1'b0;
    cyc(2);
    `chk({first_port_oe_o, second_port_oe_o}, 16'h0000)
    `chk(prog_code_o, f_val)
    `chk(prog_ctrl_o & 8'hbf, s_val & 8'hbf)
    f_en = 8'h00;
    prog_verify_i = 1'b1;
    prog_code_i = 8'ha5;
    cyc(3);
    `chk({first_port_oe_o, first_port_out_o, first_pins_o}, 24'hffa5a5)
    {prog_mode_i, prog_verify_i} = 2'b00;
    cyc(3);
    `chk(first_port_oe_o, 8'h00)
    end_of_test;
  end
endmodule
